// [rtl/jpsc_top.sv]
// Test pin sharing controller: scan pin ownership, scan reset pin,
// checksum output, probe pins and user pin buffers, under AXI4-Lite.
// Assumes pins and routed clocks are asynchronous to aclk, and that the
// test clock is slow enough for aclk to see each of its levels.
`timescale 1ns/100ps
`default_nettype none
`include "jpsc_regs.svh"
module jpsc_top import jpsc_pkg::*; (
  // Hardwired array clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output var  logic [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  // Dedicated mode-select pin
  input  wire logic        tms_pin_in,
  // Shared pins: tck, tdi, tdo, trst, probe a, probe b
  input  wire logic [5:0]  io_pin_in,
  output var  logic [5:0]  io_pin_out,
  output var  logic [5:0]  io_pin_oe_n,
  output var  logic        trst_pull_up_en,
  // Routed clocks in and buffered out
  input  wire logic        routed_clock_a_in,
  input  wire logic        routed_clock_b_in,
  output var  logic        routed_clock_a_buf,
  output var  logic        routed_clock_b_buf
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  logic [8:0]      in_s;
  logic [5:0]      pin_s;
  logic            tms_s;
  logic            tck_d;
  logic            tck_rise;
  logic            tck_fall;
  jpsc_ctrl_t      ctrl;
  logic            probe_lock;
  logic            csum_start;
  logic [7:0]      probe_sel;
  logic [11:0]     io_mode;
  logic [5:0]      io_out_reg;
  logic [5:0]      io_oe_reg;
  logic [7:0]      aw_addr;
  logic [31:0]     w_data;
  logic [3:0]      w_strb;
  logic            wr_go;
  logic [31:0]     wmask;
  logic [31:0]     status;
  logic            scan_active;
  jpsc_tap_state_t tap_state;
  logic            trst_act;
  logic            bypass;
  logic [1:0]      ir;
  logic            tdo_bit;
  logic            tdo_en;
  logic            csum_busy;
  logic [4:0]      csum_cnt;
  logic [15:0]     csum_shift;
  logic [15:0]     node;
  logic            probe_a_act;
  logic            probe_b_act;
  logic [5:0]      user_out;
  logic [5:0]      user_oe_n;
  jpsc_pins_t      next_pins;

  // ---------------------------------------------------------------
  // Pin synchronisers and test clock edges
  // ---------------------------------------------------------------
  // No-connect pins have no port and so cannot disturb the block; see R20
  jpsc_sync #(.WIDTH(9)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({routed_clock_b_in, routed_clock_a_in, ~tms_pin_in, io_pin_in}),
    .q       (in_s)
  );

  assign pin_s    = in_s[5:0];
  // Mode-select is carried inverted so its reset value reads high
  assign tms_s    = ~in_s[6];
  assign tck_rise = pin_s[`JPSC_PIN_TCK] & ~tck_d;
  assign tck_fall = ~pin_s[`JPSC_PIN_TCK] & tck_d;

  // All flip-flops run straight off the hardwired clock aclk; see R18
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= pin_s[`JPSC_PIN_TCK];
    end
  end

  // Routed clocks leave through a register stage as their buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      routed_clock_a_buf <= 1'b0;
      routed_clock_b_buf <= 1'b0;
      trst_pull_up_en    <= 1'b0;
    end else begin
      routed_clock_a_buf <= in_s[7]; // see R19
      routed_clock_b_buf <= in_s[8]; // see R19
      trst_pull_up_en    <= 1'b1;    // see R8
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channels
  // ---------------------------------------------------------------
  assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                  {8{w_strb[1]}}, {8{w_strb[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `JPSC_ADDR_CTRL || aw_addr == `JPSC_ADDR_PROBE_SEL ||
            aw_addr == `JPSC_ADDR_IO_MODE || aw_addr == `JPSC_ADDR_IO_OUT ||
            aw_addr == `JPSC_ADDR_IO_OE || aw_addr == `JPSC_ADDR_STATUS) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl       <= `JPSC_CTRL_RST;
      probe_sel  <= `JPSC_PROBE_SEL_RST;
      io_mode    <= `JPSC_IO_MODE_RST; // see R17
      io_out_reg <= `JPSC_IO_OUT_RST;
      io_oe_reg  <= `JPSC_IO_OE_RST;
    end else if (wr_go) begin
      if (aw_addr == `JPSC_ADDR_CTRL) begin
        ctrl <= (ctrl & ~wmask[3:0]) | (w_data[3:0] & wmask[3:0]);
      end else if (aw_addr == `JPSC_ADDR_PROBE_SEL) begin
        probe_sel <= (probe_sel & ~wmask[7:0]) | (w_data[7:0] & wmask[7:0]);
      end else if (aw_addr == `JPSC_ADDR_IO_MODE) begin
        io_mode <= (io_mode & ~wmask[11:0]) | (w_data[11:0] & wmask[11:0]);
      end else if (aw_addr == `JPSC_ADDR_IO_OUT) begin
        io_out_reg <= (io_out_reg & ~wmask[5:0]) | (w_data[5:0] & wmask[5:0]);
      end else if (aw_addr == `JPSC_ADDR_IO_OE) begin
        io_oe_reg <= (io_oe_reg & ~wmask[5:0]) | (w_data[5:0] & wmask[5:0]);
      end
    end
  end

  // Lock is write-one-to-set; only a device reset undoes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      probe_lock <= 1'b0;
      csum_start <= 1'b0;
    end else begin
      csum_start <= wr_go && aw_addr == `JPSC_ADDR_CTRL && w_strb[0] &&
                    w_data[`JPSC_CTRL_CSUM_START];
      if (wr_go && aw_addr == `JPSC_ADDR_CTRL && w_strb[0] &&
          w_data[`JPSC_CTRL_PROBE_LOCK]) begin
        probe_lock <= 1'b1; // see R15
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channels
  // ---------------------------------------------------------------
  always_comb begin
    status = 32'h0000_0000;
    status[`JPSC_STAT_TAP_LSB +: 4]      = tap_state;
    status[`JPSC_STAT_SCAN_ACT]          = scan_active;
    status[`JPSC_STAT_CSUM_BUSY]         = csum_busy;
    status[`JPSC_STAT_LOCKED]            = probe_lock;
    status[`JPSC_STAT_PINS_LSB +: 6]     = pin_s;
    status[`JPSC_STAT_CLK_A]             = in_s[7];
    status[`JPSC_STAT_CLK_B]             = in_s[8];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      if (s_axi_araddr == `JPSC_ADDR_CTRL) begin
        s_axi_rdata <= {26'h0, 1'b0, probe_lock, ctrl};
      end else if (s_axi_araddr == `JPSC_ADDR_PROBE_SEL) begin
        s_axi_rdata <= {24'h0, probe_sel};
      end else if (s_axi_araddr == `JPSC_ADDR_IO_MODE) begin
        s_axi_rdata <= {20'h0, io_mode};
      end else if (s_axi_araddr == `JPSC_ADDR_IO_OUT) begin
        s_axi_rdata <= {26'h0, io_out_reg};
      end else if (s_axi_araddr == `JPSC_ADDR_IO_OE) begin
        s_axi_rdata <= {26'h0, io_oe_reg};
      end else if (s_axi_araddr == `JPSC_ADDR_STATUS) begin
        s_axi_rdata <= status;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Scan pin ownership and scan state machine
  // ---------------------------------------------------------------
  assign trst_act = ctrl.reserve_trst & ~pin_s[`JPSC_PIN_TRST]; // see R9

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_active <= 1'b0;
    end else if (ctrl.dedicated_mode) begin
      scan_active <= 1'b1; // see R6
    end else if (!tms_s) begin
      scan_active <= 1'b1; // see R1 see R2 see R3
    end else if (tap_state == JPSC_ST_RESET || trst_act) begin
      scan_active <= 1'b0; // see R4 see R21
    end
  end

  jpsc_tap u_tap (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .step        (tck_rise & scan_active),
    .tms         (tms_s),
    .force_reset (trst_act),
    .state       (tap_state)
  );

  // Capture and shift on the test clock rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bypass <= 1'b0;
      ir     <= `JPSC_IR_CAPTURE;
    end else if (tck_rise && scan_active) begin
      case (tap_state)
        JPSC_ST_CAP_DR:   bypass <= 1'b0;
        JPSC_ST_SHIFT_DR: bypass <= pin_s[`JPSC_PIN_TDI]; // see R2
        JPSC_ST_CAP_IR:   ir <= `JPSC_IR_CAPTURE;
        JPSC_ST_SHIFT_IR: ir <= {pin_s[`JPSC_PIN_TDI], ir[1]};
        default:          ir <= ir;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Serial output and checksum command
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tdo_bit    <= 1'b0;
      tdo_en     <= 1'b0;
      csum_busy  <= 1'b0;
      csum_cnt   <= 5'h00;
      csum_shift <= 16'h0000;
    end else if (csum_start && !csum_busy) begin
      csum_busy  <= 1'b1;
      csum_cnt   <= 5'h00;
      csum_shift <= {io_mode, ctrl} ^ {probe_sel, 2'h0, io_out_reg};
    end else if (tck_fall) begin
      if (csum_busy) begin
        if (csum_cnt == `JPSC_CSUM_BITS) begin
          csum_busy <= 1'b0; // see R11
        end else begin
          tdo_bit    <= csum_shift[0]; // see R10
          csum_shift <= {1'b0, csum_shift[15:1]};
          csum_cnt   <= csum_cnt + 5'h01;
        end
      end else begin
        tdo_en  <= tap_state == JPSC_ST_SHIFT_DR ||
                   tap_state == JPSC_ST_SHIFT_IR;
        tdo_bit <= (tap_state == JPSC_ST_SHIFT_IR) ? ir[0] : bypass;
      end
    end
  end

  // ---------------------------------------------------------------
  // Probe selection
  // ---------------------------------------------------------------
  assign node = {tap_state, scan_active, csum_busy, tdo_bit, bypass,
                 pin_s, in_s[7], in_s[8]};
  assign probe_a_act = ctrl.probe_a_en & ~probe_lock; // see R13 see R15
  assign probe_b_act = ctrl.probe_b_en & ~probe_lock; // see R13 see R15

  // ---------------------------------------------------------------
  // User pin buffers
  // ---------------------------------------------------------------
  for (genvar i = 0; i < `JPSC_NPINS; i++) begin : g_user
    always_comb begin
      case (jpsc_io_mode_t'(io_mode[2*i +: 2])) // see R16
        JPSC_IO_OUTPUT: begin
          user_out[i]  = io_out_reg[i];
          user_oe_n[i] = 1'b0;
        end
        JPSC_IO_TRI, JPSC_IO_BIDIR: begin
          user_out[i]  = io_out_reg[i];
          user_oe_n[i] = ~io_oe_reg[i];
        end
        default: begin
          user_out[i]  = 1'b0;
          user_oe_n[i] = 1'b1; // see R17
        end
      endcase
    end
  end

  // Scan, checksum and probe functions override the user buffers
  always_comb begin
    next_pins.out  = user_out;
    next_pins.oe_n = user_oe_n;
    if (scan_active) begin
      next_pins.oe_n[`JPSC_PIN_TCK] = 1'b1; // see R1
      next_pins.oe_n[`JPSC_PIN_TDI] = 1'b1; // see R2
      next_pins.out[`JPSC_PIN_TDO]  = tdo_bit;
      next_pins.oe_n[`JPSC_PIN_TDO] = ~tdo_en; // see R3
    end
    if (csum_busy) begin
      next_pins.out[`JPSC_PIN_TDO]  = tdo_bit;
      next_pins.oe_n[`JPSC_PIN_TDO] = 1'b0; // see R10
    end
    if (ctrl.reserve_trst) begin
      next_pins.oe_n[`JPSC_PIN_TRST] = 1'b1; // see R7
    end
    if (probe_a_act) begin
      next_pins.out[`JPSC_PIN_PROBE_A]  = node[probe_sel[3:0]]; // see R12
      next_pins.oe_n[`JPSC_PIN_PROBE_A] = 1'b0;
    end
    if (probe_b_act) begin
      next_pins.out[`JPSC_PIN_PROBE_B]  = node[probe_sel[7:4]]; // see R12
      next_pins.oe_n[`JPSC_PIN_PROBE_B] = 1'b0;
    end
  end

  // Probe pins fall back to user buffers when disabled; see R14
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_pin_out  <= 6'h00;
      io_pin_oe_n <= 6'h3F;
    end else begin
      io_pin_out  <= next_pins.out;
      io_pin_oe_n <= next_pins.oe_n;
    end
  end

endmodule : jpsc_top
`default_nettype wire

// [rtl/jpsc_regs.svh]
// Register offsets, field positions, reset values and counts for the
// test pin sharing controller.
// Assumes byte addressing on a 32-bit AXI4-Lite register bus.
//
// Behaviour
// R1: Flexible mode, mode-select low: test clock pin becomes the scan clock.
// R2: Flexible mode, mode-select low: test data input pin becomes scan input.
// R3: Flexible mode, mode-select low: test data output pin drives scan output.
// R4: Shared pins stay in test mode until logic reset, then become user I/O.
// R5: Five test clocks with mode-select high reach logic reset; tester supplies.
// R6: Dedicated mode: mode-select is the plain scan mode select, no sharing.
// R7: Reserved scan reset pin low initialises the scan logic at once.
// R8: Scan reset pin has an internal pull-up, reads high when undriven.
// R9: Scan reset pin is user I/O unless reserved at configuration.
// R10: Checksum command running: test data output pin is driven.
// R11: Checksum done: test data output pin returns to user I/O.
// R12: Each probe pin outputs any selected internal node live.
// R13: Probe pins usable alone or both together.
// R14: Probe pin can be configured as plain user I/O.
// R15: Probe observation can be disabled permanently; the code's lock is cleared again by a device reset.
// R16: Each user pin is input, output, tristate or bidirectional.
// R17: Unused user pins default to tristated, undriven.
// R18: Hardwired array clock reaches every flip-flop directly.
// R19: Routed clock inputs are buffered before distribution.
// R20: No-connect pins have no link to internal logic.
// R21: Scan reset also forces logic reset, releasing the shared pins.
`ifndef JPSC_REGS_SVH
`define JPSC_REGS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define JPSC_ADDR_CTRL      8'h00
`define JPSC_ADDR_PROBE_SEL 8'h04
`define JPSC_ADDR_IO_MODE   8'h08
`define JPSC_ADDR_IO_OUT    8'h0C
`define JPSC_ADDR_IO_OE     8'h10
`define JPSC_ADDR_STATUS    8'h14

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define JPSC_CTRL_DEDICATED  0
`define JPSC_CTRL_RSV_TRST   1
`define JPSC_CTRL_PROBE_A_EN 2
`define JPSC_CTRL_PROBE_B_EN 3
`define JPSC_CTRL_PROBE_LOCK 4
`define JPSC_CTRL_CSUM_START 5

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define JPSC_STAT_TAP_LSB    0
`define JPSC_STAT_SCAN_ACT   4
`define JPSC_STAT_CSUM_BUSY  5
`define JPSC_STAT_LOCKED     6
`define JPSC_STAT_PINS_LSB   8
`define JPSC_STAT_CLK_A      14
`define JPSC_STAT_CLK_B      15

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define JPSC_CTRL_RST      4'h0
`define JPSC_PROBE_SEL_RST 8'h00
`define JPSC_IO_MODE_RST   12'h000
`define JPSC_IO_OUT_RST    6'h00
`define JPSC_IO_OE_RST     6'h00
`define JPSC_IR_CAPTURE    2'h1

// ---------------------------------------------------------------
// Shared pin indices and counts
// ---------------------------------------------------------------
`define JPSC_NPINS       6
`define JPSC_PIN_TCK     0
`define JPSC_PIN_TDI     1
`define JPSC_PIN_TDO     2
`define JPSC_PIN_TRST    3
`define JPSC_PIN_PROBE_A 4
`define JPSC_PIN_PROBE_B 5
`define JPSC_CSUM_BITS   5'h10

`endif

// [rtl/jpsc_pkg.sv]
// Types of the test pin sharing controller.
// Assumes nothing beyond a SystemVerilog compiler.
package jpsc_pkg;

  // ---------------------------------------------------------------
  // Scan state machine states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    JPSC_ST_RESET    = 4'h0,
    JPSC_ST_IDLE     = 4'h1,
    JPSC_ST_SEL_DR   = 4'h2,
    JPSC_ST_CAP_DR   = 4'h3,
    JPSC_ST_SHIFT_DR = 4'h4,
    JPSC_ST_EXIT1_DR = 4'h5,
    JPSC_ST_PAUSE_DR = 4'h6,
    JPSC_ST_EXIT2_DR = 4'h7,
    JPSC_ST_UPD_DR   = 4'h8,
    JPSC_ST_SEL_IR   = 4'h9,
    JPSC_ST_CAP_IR   = 4'hA,
    JPSC_ST_SHIFT_IR = 4'hB,
    JPSC_ST_EXIT1_IR = 4'hC,
    JPSC_ST_PAUSE_IR = 4'hD,
    JPSC_ST_EXIT2_IR = 4'hE,
    JPSC_ST_UPD_IR   = 4'hF
  } jpsc_tap_state_t;

  // ---------------------------------------------------------------
  // User pin buffer modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    JPSC_IO_INPUT  = 2'h0,
    JPSC_IO_OUTPUT = 2'h1,
    JPSC_IO_TRI    = 2'h2,
    JPSC_IO_BIDIR  = 2'h3
  } jpsc_io_mode_t;

  // Writable control bits
  typedef struct packed {
    logic probe_b_en;
    logic probe_a_en;
    logic reserve_trst;
    logic dedicated_mode;
  } jpsc_ctrl_t;

  // Drive of the shared pins
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe_n;
  } jpsc_pins_t;

endpackage : jpsc_pkg

// [rtl/jpsc_sync.sv]
// Two flip-flop synchroniser for pins entering the aclk domain.
// Assumes inputs asynchronous to aclk; the first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module jpsc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : jpsc_sync
`default_nettype wire

// [rtl/jpsc_tap.sv]
// Scan state machine, stepped once per sampled test clock rise.
// Assumes step is a one-cycle pulse and tms is already synchronised.
`timescale 1ns/100ps
`default_nettype none
module jpsc_tap import jpsc_pkg::*; (
  // Clock and reset
  input  wire logic      aclk,
  input  wire logic      aresetn,
  // Scan controls
  input  wire logic      step,
  input  wire logic      tms,
  input  wire logic      force_reset,
  output var  jpsc_tap_state_t state
);
  jpsc_tap_state_t next_state;

  always_comb begin
    case (state)
      JPSC_ST_RESET:    next_state = tms ? JPSC_ST_RESET : JPSC_ST_IDLE;
      JPSC_ST_IDLE:     next_state = tms ? JPSC_ST_SEL_DR : JPSC_ST_IDLE;
      JPSC_ST_SEL_DR:   next_state = tms ? JPSC_ST_SEL_IR : JPSC_ST_CAP_DR;
      JPSC_ST_CAP_DR:   next_state = tms ? JPSC_ST_EXIT1_DR : JPSC_ST_SHIFT_DR;
      JPSC_ST_SHIFT_DR: next_state = tms ? JPSC_ST_EXIT1_DR : JPSC_ST_SHIFT_DR;
      JPSC_ST_EXIT1_DR: next_state = tms ? JPSC_ST_UPD_DR : JPSC_ST_PAUSE_DR;
      JPSC_ST_PAUSE_DR: next_state = tms ? JPSC_ST_EXIT2_DR : JPSC_ST_PAUSE_DR;
      JPSC_ST_EXIT2_DR: next_state = tms ? JPSC_ST_UPD_DR : JPSC_ST_SHIFT_DR;
      JPSC_ST_UPD_DR:   next_state = tms ? JPSC_ST_SEL_DR : JPSC_ST_IDLE;
      JPSC_ST_SEL_IR:   next_state = tms ? JPSC_ST_RESET : JPSC_ST_CAP_IR;
      JPSC_ST_CAP_IR:   next_state = tms ? JPSC_ST_EXIT1_IR : JPSC_ST_SHIFT_IR;
      JPSC_ST_SHIFT_IR: next_state = tms ? JPSC_ST_EXIT1_IR : JPSC_ST_SHIFT_IR;
      JPSC_ST_EXIT1_IR: next_state = tms ? JPSC_ST_UPD_IR : JPSC_ST_PAUSE_IR;
      JPSC_ST_PAUSE_IR: next_state = tms ? JPSC_ST_EXIT2_IR : JPSC_ST_PAUSE_IR;
      JPSC_ST_EXIT2_IR: next_state = tms ? JPSC_ST_UPD_IR : JPSC_ST_SHIFT_IR;
      JPSC_ST_UPD_IR:   next_state = tms ? JPSC_ST_SEL_DR : JPSC_ST_IDLE;
      default:          next_state = JPSC_ST_RESET;
    endcase
  end

  // Any state reaches reset within five steps with tms high
  always_ff @(posedge aclk) begin
    if (!aresetn || force_reset) begin // see R7 see R21
      state <= JPSC_ST_RESET;
    end else if (step) begin
      state <= next_state; // see R5
    end
  end
endmodule : jpsc_tap
`default_nettype wire

// [verif/jpsc_asserts.sv]
// Checker for the pin sharing controller.
// Assumes it is bound to jpsc_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module jpsc_asserts (
  // Clock, reset and pins
  input wire logic        aclk, aresetn, trst_pull_up_en,
  input wire logic        routed_clock_a_in, routed_clock_a_buf,
  input wire logic [5:0]  io_pin_oe_n,
  // Register bus
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_PULL_UP: assert property ($past(aresetn) |-> trst_pull_up_en)
    else $error("trst pull-up off");
  AST_CLK_BUF: assert property (aresetn [*4] |->
    routed_clock_a_buf == $past(routed_clock_a_in, 3))
    else $error("routed clock a not buffered");
  AST_RST_TRI: assert property (disable iff (1'b0)
    !aresetn |=> io_pin_oe_n == 6'h3F) else $error("pins driven in reset");
  AST_AW_TAKE: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready) else $error("awready stays high");
  AST_W_RESP: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (io_pin_oe_n == 6'h03);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : jpsc_asserts
bind jpsc_top jpsc_asserts u_chk (.*);
`default_nettype wire

// [verif/jpsc_tester.sv]
// Scan tester model driving test clock, mode-select and data-in.
// Assumes its clock is unrelated to aclk; clock stands low between frames.
`timescale 1ns/100ps
`default_nettype none
module jpsc_tester (
  // Scan link
  output var logic tck, tms, tdi
);
  initial {tck, tms, tdi} = 3'b010;
  // One 83 ns scan clock, tms and tdi set while it is low
  task automatic cyc(input logic m, input logic d);
    #3 {tms, tdi} = {m, d};
    #40 tck = 1'b1;
    #40 tck = 1'b0;
  endtask : cyc
endmodule : jpsc_tester
`default_nettype wire

// [verif/jpsc_top_test.sv]
// Self-checking bench for the pin sharing controller.
// Assumes jpsc_top, the tester model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  err_count++; $display("FAIL %s exp %h got %h", n, e, g); end end
module jpsc_top_test import jpsc_pkg::*;;
  logic aclk = 0, aresetn = 0, routed_clock_a_in = 0, routed_clock_b_in = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, trst_en = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, trst_pull_up_en, routed_clock_a_buf, routed_clock_b_buf;
  logic tck, tdi, tms_pin_in;
  logic [5:0] io_pin_in, io_pin_out, io_pin_oe_n;
  int err_count = 0, n_tests = 0;
  assign io_pin_in = ~io_pin_oe_n & io_pin_out | io_pin_oe_n &
    {2'h0, !trst_en && trst_pull_up_en, 1'b0, tdi, tck};
  jpsc_top uut (.*);
  jpsc_tester tst (.tck(tck), .tms(tms_pin_in), .tdi(tdi));
  always #5 aclk = ~aclk;
  always #8 routed_clock_a_in = ~routed_clock_a_in;
  always #6 routed_clock_b_in = ~routed_clock_b_in;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk) {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk) resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk) {s_axi_arvalid, s_axi_araddr} <= {1'b1, a};
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk) {rd_data, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    #100000 err_count++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00); `CHK("ctrl", 32'h0, rd_data)
    rd(8'h04); `CHK("probe_sel", 32'h0, rd_data)
    rd(8'h18); `CHK("rd unmapped", 2'h2, resp)
    wr(8'h18, 32'h1); `CHK("wr unmapped", 2'h2, resp)
    $display("test registers done");
    wr(8'h08, 32'h555); repeat (3) @(posedge aclk);
    `CHK("user out", 6'h00, io_pin_oe_n)
    tst.cyc(0, 0); tst.cyc(1, 0); tst.cyc(0, 0); tst.cyc(0, 1);
    #60 `CHK("scan oe", 6'h03, io_pin_oe_n)
    `CHK("tdo cap", 1'b0, io_pin_out[2])
    tst.cyc(0, 1); #60 `CHK("tdo shift", 1'b1, io_pin_out[2])
    repeat (4) tst.cyc(1, 0);
    #60 `CHK("held", 2'h3, io_pin_oe_n[1:0])
    tst.cyc(1, 0); #60 `CHK("freed", 6'h00, io_pin_oe_n)
    $display("test scan pins done");
    wr(8'h00, 32'h2); repeat (3) @(posedge aclk);
    `CHK("trst in", 1'b1, io_pin_oe_n[3])
    tst.cyc(0, 0); #60 `CHK("scan on", 2'h3, io_pin_oe_n[1:0])
    tst.cyc(1, 0); @(posedge aclk) trst_en <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(8'h14); `CHK("trst reset", 5'h00, rd_data[4:0])
    `CHK("trst free", 2'h0, io_pin_oe_n[1:0])
    `CHK("pull-up", 1'b1, trst_pull_up_en)
    trst_en <= 1'b0;
    $display("test scan reset done");
    wr(8'h00, 32'h10); wr(8'h00, 32'h0);
    rd(8'h00); `CHK("lock", 32'h10, rd_data)
    wr(8'h04, 32'hB); wr(8'h00, 32'h5); repeat (4) @(posedge aclk);
    `CHK("no probe", 1'b0, io_pin_out[4])
    rd(8'h14); `CHK("dedicated", 1'b1, rd_data[4])
    $display("test lock and dedicated done");
    report_and_stop;
  end
endmodule : jpsc_top_test
`default_nettype wire
